// ==== design/ccg_pkg.sv ====
// Package for the clock configuration and auxiliary clock generator.
// Assumes byte-wide register access from the serial control port decoder.
package ccg_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_ID = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_RCR = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_MCR = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_ACR = 7'h03;
  // Reset values before the strap bits are applied
  localparam logic [DATA_W-1:0] RCR_RESET = 8'h18;
  localparam logic [DATA_W-1:0] MCR_RESET = 8'h34;
  localparam logic [DATA_W-1:0] ACR_RESET = 8'h2A;
  localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;
  // Field positions
  localparam int RCR_PREDIV_HI = 7;
  localparam int RCR_PREDIV_LO = 6;
  localparam int RCR_DIRECT_CLOCK_SELECT = 5;
  localparam int RCR_MULT_HI = 4;
  localparam int RCR_MULT_LO = 0;
  localparam int MCR_STANDBY_CONTROL = 7;
  localparam int MCR_VCO_OFF = 6;
  localparam int MCR_SERIAL_CLOCK_LIMIT_SELECT = 3;
  localparam int MCR_PDIV_HI = 2;
  localparam int MCR_PDIV_LO = 0;
  localparam int ACR_PRE_HI = 7;
  localparam int ACR_PRE_LO = 5;
  localparam int ACR_DIV_HI = 4;
  localparam int ACR_DIV_LO = 0;
  localparam int ACR_LEVEL = 0;
  // Auxiliary generator
  // Code 111 needs a half count of 131072 ticks, one bit past 17
  localparam int PRE_W = 18;
  localparam int DIV_W = 6;
  localparam logic [2:0] PRE_STATIC = 3'h0;
  localparam logic [2:0] PRE_HF = 3'h1;
  localparam logic [2:0] PRE_LF_FIRST = 3'h2;
  // Half periods in VCO ticks: HF is /4, LF is 64 * 64 at the first code
  localparam logic [PRE_W-1:0] HF_HALF = 18'h00004;
  localparam logic [PRE_W-1:0] LF_HALF_BASE = 18'h01000;
  localparam logic [DIV_W-1:0] LF_DIV_BASE = 6'h20;
  localparam logic [4:0] DIV_ZERO = 5'h00;
  // Straps are sampled this many cycles after reset release
  localparam logic [1:0] STRAP_LOAD = 2'h2;
endpackage

// ==== design/ccg_top.sv ====
// Clock configuration registers and auxiliary clock generator.
// Assumes a same-clock register port from the serial control decoder and a
// one-cycle VCO tick enable in the i_mclk domain; strap pins are async.
`timescale 1ns/100ps

module ccg_top #(
  parameter logic [7:0] RELEASE_ID = 8'h5C // Arbitrary value
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [ccg_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [ccg_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_vco_tick,
  input wire logic i_direct_clock_disable_pin,
  input wire logic i_standby_pin,
  output logic [ccg_pkg::DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic [1:0] o_predivider,
  output logic o_direct_clock_select,
  output logic [4:0] o_multiplier,
  output logic o_standby_control,
  output logic o_vco_off,
  output logic o_serial_clock_limit_select,
  output logic [2:0] o_master_divider,
  output logic o_aux_clk
);
  import ccg_pkg::*;

  logic [DATA_W-1:0] reference_clock_config;
  logic [DATA_W-1:0] master_clock_config;
  logic [DATA_W-1:0] auxiliary_clock_config;
  logic [1:0] dcd_sync;
  logic [1:0] stb_sync;
  logic [1:0] init_cnt;
  logic [PRE_W-1:0] pre_cnt;
  logic [DIV_W-1:0] div_cnt;

  // Decode
  wire wr_rcr = i_reg_wr && (i_reg_addr == ADDR_RCR);
  wire wr_mcr = i_reg_wr && (i_reg_addr == ADDR_MCR);
  wire wr_acr = i_reg_wr && (i_reg_addr == ADDR_ACR);
  wire strap_now = (init_cnt == STRAP_LOAD);

  // two's complement passthrough
  // None of these registers is signed, so bits are returned unchanged.
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    unique case (i_reg_addr)
      ADDR_ID: next_rdata = RELEASE_ID;
      ADDR_RCR: next_rdata = reference_clock_config;
      ADDR_MCR: next_rdata = master_clock_config;
      ADDR_ACR: next_rdata = auxiliary_clock_config;
      default: next_rdata = RDATA_NONE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= RDATA_NONE;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  // Strap pins are asynchronous to i_mclk
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dcd_sync <= 2'h0;
      stb_sync <= 2'h0;
      init_cnt <= 2'h0;
    end else begin
      dcd_sync <= {dcd_sync[0], i_direct_clock_disable_pin};
      stb_sync <= {stb_sync[0], i_standby_pin};
      if (init_cnt != STRAP_LOAD + 2'h1) begin
        init_cnt <= init_cnt + 2'h1;
      end
    end
  end

  // reference clock fields and strap
  // Reset takes constants; the strap lands once synchronised. A write in
  // the same cycle wins; a write one cycle earlier loses bit 5 to the strap.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      reference_clock_config <= RCR_RESET;
    end else if (wr_rcr) begin
      reference_clock_config <= i_reg_wdata;
    end else if (strap_now) begin
      reference_clock_config[RCR_DIRECT_CLOCK_SELECT] <= ~dcd_sync[1];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      master_clock_config <= MCR_RESET;
    end else if (wr_mcr) begin
      master_clock_config <= i_reg_wdata;
    end else if (strap_now) begin
      master_clock_config[MCR_STANDBY_CONTROL] <= stb_sync[1];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      auxiliary_clock_config <= ACR_RESET;
    end else if (wr_acr) begin
      auxiliary_clock_config <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_predivider <= RCR_RESET[RCR_PREDIV_HI:RCR_PREDIV_LO];
      o_direct_clock_select <= RCR_RESET[RCR_DIRECT_CLOCK_SELECT];
      o_multiplier <= RCR_RESET[RCR_MULT_HI:RCR_MULT_LO];
      o_standby_control <= MCR_RESET[MCR_STANDBY_CONTROL];
      o_vco_off <= MCR_RESET[MCR_VCO_OFF];
      o_serial_clock_limit_select <= MCR_RESET[MCR_SERIAL_CLOCK_LIMIT_SELECT];
      o_master_divider <= MCR_RESET[MCR_PDIV_HI:MCR_PDIV_LO];
    end else begin
      o_predivider <= reference_clock_config[RCR_PREDIV_HI:RCR_PREDIV_LO];
      o_direct_clock_select <= reference_clock_config[RCR_DIRECT_CLOCK_SELECT];
      o_multiplier <= reference_clock_config[RCR_MULT_HI:RCR_MULT_LO];
      o_standby_control <= master_clock_config[MCR_STANDBY_CONTROL];
      o_vco_off <= master_clock_config[MCR_VCO_OFF];
      o_serial_clock_limit_select <= master_clock_config[MCR_SERIAL_CLOCK_LIMIT_SELECT];
      o_master_divider <= master_clock_config[MCR_PDIV_HI:MCR_PDIV_LO];
    end
  end

  // Auxiliary generator selection
  wire [2:0] pre_code = auxiliary_clock_config[ACR_PRE_HI:ACR_PRE_LO];
  wire [4:0] div_field = auxiliary_clock_config[ACR_DIV_HI:ACR_DIV_LO];
  wire mode_static = (pre_code == PRE_STATIC);
  wire mode_hf = (pre_code == PRE_HF);
  // HF with a zero divider has no defined rate, so the output holds low.
  wire gen_on = !mode_static && !(mode_hf && (div_field == DIV_ZERO));
  wire [2:0] lf_shift = pre_code - PRE_LF_FIRST;
  wire [PRE_W-1:0] pre_half = mode_hf ? HF_HALF : (LF_HALF_BASE << lf_shift);
  wire [DIV_W-1:0] div_len = mode_hf ? {1'b0, div_field}
                                     : (LF_DIV_BASE + {1'b0, div_field});
  // No ticks arrive while the VCO is switched off
  wire tick = i_vco_tick && !master_clock_config[MCR_VCO_OFF] && gen_on;
  wire pre_end = tick && (pre_cnt == pre_half - 18'h00001);
  wire div_end = pre_end && (div_cnt == div_len - 6'h01);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt <= '0;
      div_cnt <= '0;
    end else if (wr_acr) begin
      pre_cnt <= '0;
      div_cnt <= '0;
    end else if (tick) begin
      pre_cnt <= pre_end ? '0 : pre_cnt + 18'h00001;
      if (pre_end) begin
        div_cnt <= div_end ? '0 : div_cnt + 6'h01;
      end
    end
  end

  // square wave toggling
  // Toggling once per half period keeps the duty cycle exactly half.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_aux_clk <= 1'b0;
    end else if (mode_static) begin
      o_aux_clk <= auxiliary_clock_config[ACR_LEVEL];
    end else if (wr_acr || !gen_on) begin
      o_aux_clk <= 1'b0;
    end else if (div_end) begin
      o_aux_clk <= ~o_aux_clk;
    end
  end

  chk_id_read_only: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_reg_rd && (i_reg_addr == ADDR_ID) |=> o_reg_rdata == RELEASE_ID)
    else $error("identifier read wrong");

  chk_rcr_write_stores: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_rcr |=> ##1 o_multiplier == $past(i_reg_wdata[4:0], 2))
    else $error("reference clock write lost");

  chk_mcr_vco_out: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_mcr |=> ##1 o_vco_off == $past(i_reg_wdata[MCR_VCO_OFF], 2))
    else $error("vco control not applied");

  chk_strap_standby: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    strap_now && !wr_mcr |=>
      master_clock_config[MCR_STANDBY_CONTROL] == $past(stb_sync[1]))
    else $error("standby strap not loaded");

  chk_acr_restart: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_acr |=> pre_cnt == '0 && div_cnt == '0 && (!gen_on || !o_aux_clk))
    else $error("aux counters not restarted");

  chk_static_level: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    mode_static && !wr_acr |=> o_aux_clk == $past(auxiliary_clock_config[0]))
    else $error("static aux level wrong");

  chk_toggle_cause: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    !mode_static && gen_on && !wr_acr && !div_end |=> $stable(o_aux_clk))
    else $error("aux toggled without divider end");

  chk_vco_off_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    master_clock_config[MCR_VCO_OFF] && !wr_acr |=> $stable(pre_cnt))
    else $error("generator ran with vco off");

  chk_hf_half_len: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    mode_hf && tick && pre_cnt == 18'h00003 && !wr_acr |=> pre_cnt == '0)
    else $error("hf prescale not four ticks");

  // A strap landing one cycle after a write may legally alter bit 5
  chk_rcr_fields: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_rcr ##1 !strap_now |=>
      o_predivider == $past(i_reg_wdata[RCR_PREDIV_HI:RCR_PREDIV_LO], 2) &&
      o_direct_clock_select == $past(i_reg_wdata[RCR_DIRECT_CLOCK_SELECT], 2))
    else $error("reference clock fields wrong");

  chk_strap_direct_clock_select: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    strap_now && !wr_rcr |=>
      reference_clock_config[RCR_DIRECT_CLOCK_SELECT] == !$past(dcd_sync[1]))
    else $error("direct clock strap not loaded");

  chk_standby_control_write: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_mcr ##1 !strap_now |=>
      o_standby_control == $past(i_reg_wdata[MCR_STANDBY_CONTROL], 2))
    else $error("standby write not applied");

  chk_mcr_fields: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_mcr |=> ##1
      o_serial_clock_limit_select == $past(i_reg_wdata[MCR_SERIAL_CLOCK_LIMIT_SELECT], 2) &&
      o_master_divider == $past(i_reg_wdata[MCR_PDIV_HI:MCR_PDIV_LO], 2))
    else $error("master clock fields wrong");

  chk_aux_write: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_acr |=> auxiliary_clock_config == $past(i_reg_wdata))
    else $error("auxiliary write lost");

  chk_read_valid: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_reg_rd |=> o_reg_rvalid)
    else $error("read valid missing");

  chk_rdata_hold: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");

  chk_unmapped_read: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_reg_rd && (i_reg_addr > ADDR_ACR) |=> o_reg_rdata == RDATA_NONE)
    else $error("unmapped read not zero");

  chk_hf_zero_low: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b)
    mode_hf && (div_field == DIV_ZERO) && !wr_acr |=> !o_aux_clk)
    else $error("hf zero divider not low");
endmodule

// ==== tb/ccg_top_test.sv ====
// Self-checking bench for the clock configuration registers and aux clock.
// Assumes a tick input held high, so one VCO tick arrives every cycle.
`timescale 1ns/100ps
module ccg_top_test;
  import ccg_pkg::*;
  // Arbitrary value
  localparam logic [7:0] REL = 8'h5C;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [ADDR_W-1:0] i_reg_addr = '0;
  logic [DATA_W-1:0] i_reg_wdata = '0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_vco_tick = 1'b1;
  logic i_dis = 1'b1;
  logic i_sby = 1'b0;
  logic [DATA_W-1:0] o_reg_rdata;
  logic o_reg_rvalid, o_dsel, o_sby, o_voff, o_slim, o_aux_clk;
  logic [1:0] o_pre;
  logic [4:0] o_mult;
  logic [2:0] o_mdiv;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  ccg_top #(.RELEASE_ID(REL)) uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_vco_tick(i_vco_tick),
    .i_direct_clock_disable_pin(i_dis), .i_standby_pin(i_sby),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_predivider(o_pre), .o_direct_clock_select(o_dsel),
    .o_multiplier(o_mult), .o_standby_control(o_sby), .o_vco_off(o_voff),
    .o_serial_clock_limit_select(o_slim), .o_master_divider(o_mdiv),
    .o_aux_clk(o_aux_clk));
  always #2 i_mclk = ~i_mclk;
  // Run needs a few thousand cycles; this ceiling catches a hang
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    step(1);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e,
                    input string nm);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    step(1);
    i_reg_rd = 1'b0;
    chk({nm, " valid"}, 8'h01, {7'h00, o_reg_rvalid});
    chk(nm, e, o_reg_rdata);
  endtask
  task automatic fields(input logic [7:0] r, input logic [7:0] m);
    chk("ref fields", r, {o_pre, o_dsel, o_mult});
    chk("mst fields", m, {o_sby, o_voff, m[5:4], o_slim, o_mdiv});
  endtask
  task automatic until_aux(input logic v, output int k);
    k = 0;
    while (o_aux_clk !== v && k < 400) begin
      step(1);
      k++;
    end
  endtask
  // Full high and low phases, each four ticks per divider step
  task automatic hf_half(input int n);
    int k;
    until_aux(1'b0, k);
    until_aux(1'b1, k);
    until_aux(1'b0, k);
    chk("hf high", 8'(4 * n), 8'(k));
    until_aux(1'b1, k);
    chk("hf low", 8'(4 * n), 8'(k));
  endtask
  task automatic t_reset(input logic dis, input logic sby,
                         input logic [7:0] r, input logic [7:0] m);
    i_dis = dis;
    i_sby = sby;
    i_rst_b = 1'b0;
    step(8);
    i_rst_b = 1'b1;
    step(5);
    rd(ADDR_ID, REL, "id");
    rd(ADDR_RCR, r, "rcr reset");
    rd(ADDR_MCR, m, "mcr reset");
    rd(ADDR_ACR, 8'h2A, "acr reset");
    fields(r, m);
    hf_half(10);
    $display("test reset done");
  endtask
  task automatic t_regs();
    wr(ADDR_ID, 8'hFF);
    rd(ADDR_ID, REL, "id after write");
    wr(7'h4E, 8'h00);
    rd(7'h10, 8'h00, "unmapped");
    wr(ADDR_RCR, 8'hC7);
    wr(ADDR_MCR, 8'h7B);
    step(1);
    fields(8'hC7, 8'h7B);
    rd(ADDR_RCR, 8'hC7, "rcr rw");
    wr(ADDR_RCR, 8'h38);
    wr(ADDR_MCR, 8'hB4);
    step(1);
    fields(8'h38, 8'hB4);
    rd(ADDR_MCR, 8'hB4, "mcr rw");
    wr(ADDR_MCR, 8'h34);
    $display("test regs done");
  endtask
  task automatic t_static();
    logic [7:0] sv [4] = '{8'h01, 8'h1E, 8'h1F, 8'h00};
    foreach (sv[i]) begin
      wr(ADDR_ACR, sv[i]);
      step(1);
      chk("static", {7'h00, sv[i][0]}, {7'h00, o_aux_clk});
      step(30);
      chk("static hold", {7'h00, sv[i][0]}, {7'h00, o_aux_clk});
    end
    $display("test static done");
  endtask
  // Each write after the first lands one cycle into a high phase of the previous setting
  task automatic t_hf();
    int ns [3] = '{1, 2, 31};
    int k;
    foreach (ns[i]) begin
      wr(ADDR_ACR, {3'b001, 5'(ns[i])});
      until_aux(1'b1, k);
      chk("hf restart", 8'(4 * ns[i]), 8'(k));
      hf_half(ns[i]);
    end
    wr(ADDR_ACR, 8'h20);
    step(60);
    chk("hf zero", 8'h00, {7'h00, o_aux_clk});
    $display("test hf done");
  endtask
  task automatic t_gate();
    wr(ADDR_MCR, 8'h74);
    wr(ADDR_ACR, 8'h21);
    step(30);
    chk("vco off", 8'h00, {7'h00, o_aux_clk});
    wr(ADDR_MCR, 8'h34);
    hf_half(1);
    $display("test gate done");
  endtask
  // Low-frequency half periods exceed 100k ticks, so only no early edge
  task automatic t_lf();
    for (int c = 2; c < 8; c++) begin
      wr(ADDR_ACR, {3'(c), 5'h00});
      step(150);
      chk("lf quiet", 8'h00, {7'h00, o_aux_clk});
    end
    $display("test lf done");
  endtask
  initial begin
    t_reset(1'b1, 1'b0, 8'h18, 8'h34);
    t_regs();
    t_static();
    t_hf();
    t_gate();
    t_lf();
    t_reset(1'b0, 1'b1, 8'h38, 8'hB4);
    complete_run();
  end
endmodule
